// ### hw/ebt_timer.sv
// Eight-bit down timer with demodulation capture and APB registers
`timescale 1ns/1ps
`include "ebt_params.svh"
module ebt_timer
    import ebt_pkg::*;
(
    input wire logic pclk, // 50 MHz clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic stop_wake_recovery, // Stop-mode recovery pulse
    input wire logic edge_input_pin, // Demodulation input
    input wire logic alt_edge_pin, // Alternate demodulation input
    input wire logic port_out_value, // Ordinary port output level
    output logic timer_output_pin, // Pin carrying timer output
    output logic irq // Level interrupt request
);
    ebt_ctrl_s ctrl_reg, ctrl_next;
    ebt_shared_s sh_reg, sh_next;
    ebt_state_e state_reg, state_next;
    logic [7:0] reload_low_reg, reload_low_next;
    logic [7:0] reload_high_reg, reload_high_next;
    logic [7:0] short_down_counter_reg, short_down_counter_next;
    logic short_counter_output_level_reg, short_counter_output_level_next;
    logic stop_pend_reg, stop_pend_next;
    logic clr_pend_reg, clr_pend_next;
    logic [`EBT_DIV_W-1:0] div_reg, div_next;
    logic edge_prev_reg, edge_prev_next;
    logic [1:0] irq_stat_reg, irq_stat_next;
    logic [1:0] irq_mask_reg, irq_mask_next;
    logic [31:0] prdata_reg, prdata_next;
    logic cap_rd_reg, cap_rd_next;
    logic [7:0] cap_rd_data;
    ebt_cap_wr_s cap_wr;

    logic setup, wr_acc, rd_acc, tick, edge_in, rise, fall, edge_q;
    logic terminal, to_evt;

    function automatic logic [`EBT_DIV_W-1:0] div_mask(
        input logic [1:0] sel);
        div_mask = `EBT_DIV_W'((5'h2 << sel) - 5'h1);
    endfunction

    function automatic logic hit(input logic [7:0] ofs);
        hit = (paddr == ofs);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= `EBT_OFS_IRQ_MASK);
    endfunction

    // Zero-wait slave: setup registers read data, access completes
    assign pready = 1'b1;
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && mapped(paddr);
    assign rd_acc = psel && penable && !pwrite && mapped(paddr);
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata = cap_rd_reg ? {24'h0, cap_rd_data} : prdata_reg;

    // Free-running prescaler, so the first tick lands anywhere
    assign tick = ((div_reg & div_mask(ctrl_reg.clksel))
        == div_mask(ctrl_reg.clksel)); // RL5

    assign edge_in = sh_reg.pinsel ? alt_edge_pin
        : edge_input_pin; // RL15
    assign rise = edge_in && !edge_prev_reg;
    assign fall = !edge_in && edge_prev_reg;
    assign edge_q = (rise && sh_reg.edgesel[0])
        || (fall && sh_reg.edgesel[1]); // RL13

    // Enable gates it too: a wake or stop leaves one cycle in COUNT
    assign terminal = tick && (state_reg == EBT_COUNT) && !sh_reg.demod
        && ctrl_reg.en && (short_down_counter_reg == `EBT_TERMINAL);
    assign to_evt = terminal;

    always_comb begin
        cap_wr.we = (state_reg == EBT_COUNT) && sh_reg.demod
            && edge_q && ctrl_reg.en; // RL14
        cap_wr.sel = fall && !rise; // RL17
        cap_wr.data = ~short_down_counter_reg; // RL14
    end

    ebt_capture_mem u_cap (
        .pclk(pclk),
        .presetn(presetn),
        .wr(cap_wr),
        .rd_sel(paddr[2]),
        .rd_data(cap_rd_data)
    );

    always_comb begin
        ctrl_next = ctrl_reg;
        sh_next = sh_reg;
        reload_low_next = reload_low_reg;
        reload_high_next = reload_high_reg;
        irq_mask_next = irq_mask_reg;
        stop_pend_next = stop_pend_reg;
        clr_pend_next = clr_pend_reg;
        irq_stat_next = irq_stat_reg;
        if (rd_acc && hit(`EBT_OFS_IRQ_STAT)) begin
            irq_stat_next = 2'h0;
        end
        // Events after the read-clear so a same-cycle event survives
        if (to_evt && ctrl_reg.ie) begin
            irq_stat_next[`EBT_IRQ_TIMEOUT] = 1'b1; // RL10 RL18
        end
        if (cap_wr.we) begin
            irq_stat_next[`EBT_IRQ_CAPTURE] = 1'b1;
        end
        if (wr_acc && hit(`EBT_OFS_CTRL)) begin
            ctrl_next.sp = pwdata[`EBT_CTRL_SP];
            ctrl_next.clksel = pwdata[`EBT_CTRL_CLK_HI:`EBT_CTRL_CLK_LO];
            ctrl_next.ie = pwdata[`EBT_CTRL_IE];
            ctrl_next.route = pwdata[`EBT_CTRL_ROUTE];
            if (pwdata[`EBT_CTRL_EN]) begin
                ctrl_next.en = 1'b1; // RL1
                stop_pend_next = 1'b0;
            end else if (ctrl_reg.en) begin
                stop_pend_next = 1'b1; // RL8
            end
            if (pwdata[`EBT_CTRL_TS]) begin
                clr_pend_next = 1'b1; // RL8
            end
        end
        if (wr_acc && hit(`EBT_OFS_SHARED)) begin
            sh_next.demod = pwdata[`EBT_SH_DEMOD];
            sh_next.pinsel = pwdata[`EBT_SH_PINSEL];
            sh_next.edgesel = pwdata[`EBT_SH_EDGE_HI:`EBT_SH_EDGE_LO];
            sh_next.init_lvl = pwdata[`EBT_SH_INIT];
        end
        if (wr_acc && hit(`EBT_OFS_RELOAD_LO)) begin
            reload_low_next = pwdata[7:0];
        end
        if (wr_acc && hit(`EBT_OFS_RELOAD_HI)) begin
            reload_high_next = pwdata[7:0];
        end
        if (wr_acc && hit(`EBT_OFS_IRQ_MASK)) begin
            irq_mask_next = pwdata[1:0];
        end
        // Deferred stop and clear act on the timer clock
        if (tick && stop_pend_reg) begin
            ctrl_next.en = 1'b0; // RL8
            stop_pend_next = 1'b0;
        end
        if (tick && clr_pend_reg) begin
            ctrl_next.ts = 1'b0; // RL3 RL8
            clr_pend_next = 1'b0;
        end
        if (terminal && ctrl_reg.sp) begin
            ctrl_next.en = 1'b0; // RL2
        end
        if (to_evt) begin
            ctrl_next.ts = 1'b1; // RL3
        end
        if (stop_wake_recovery) begin
            ctrl_next.en = 1'b0;
            ctrl_next.sp = 1'b0;
            ctrl_next.clksel = 2'h0;
            ctrl_next.route = 1'b0;
            stop_pend_next = 1'b0; // RL10
        end
    end

    always_comb begin
        state_next = state_reg;
        short_down_counter_next = short_down_counter_reg;
        short_counter_output_level_next = short_counter_output_level_reg;
        case (state_reg)
            EBT_IDLE: begin
                if (ctrl_reg.en) begin
                    short_counter_output_level_next = sh_reg.init_lvl;
                    if (sh_reg.demod) begin
                        state_next = EBT_WAIT_EDGE;
                    end else begin
                        state_next = EBT_COUNT;
                        short_down_counter_next = sh_reg.init_lvl
                            ? reload_high_reg : reload_low_reg; // RL16
                    end
                end
            end
            EBT_WAIT_EDGE: begin
                if (edge_q) begin
                    state_next = EBT_COUNT; // RL13
                    short_down_counter_next = short_counter_output_level_reg
                        ? reload_high_reg : reload_low_reg; // RL16
                end
            end
            EBT_COUNT: begin
                if (terminal) begin
                    short_counter_output_level_next =
                        !short_counter_output_level_reg;
                    if (ctrl_reg.sp) begin
                        state_next = EBT_IDLE; // RL2
                    end else begin
                        short_down_counter_next =
                            short_counter_output_level_reg
                            ? reload_low_reg : reload_high_reg; // RL2 RL16
                    end
                end else if (tick) begin
                    // In demodulation zero simply wraps to FFh
                    short_down_counter_next =
                        short_down_counter_reg - 8'h01; // RL7
                end
            end
            default: begin
                state_next = EBT_IDLE;
            end
        endcase
        if (!ctrl_reg.en) begin
            state_next = EBT_IDLE;
        end
    end

    always_comb begin
        div_next = div_reg + `EBT_DIV_W'(1);
        edge_prev_next = edge_in;
        cap_rd_next = setup && !pwrite && (paddr == `EBT_OFS_CAP_RISE
            || paddr == `EBT_OFS_CAP_FALL);
        prdata_next = prdata_reg;
        if (setup) begin
            case (paddr)
                `EBT_OFS_CTRL: prdata_next = {24'h0, ctrl_reg.en,
                    ctrl_reg.sp, ctrl_reg.ts, ctrl_reg.clksel, 1'b0,
                    ctrl_reg.ie, ctrl_reg.route};
                `EBT_OFS_SHARED: prdata_next = {24'h0, sh_reg.demod,
                    sh_reg.pinsel, sh_reg.edgesel, 2'h0, sh_reg.init_lvl,
                    1'b0};
                `EBT_OFS_RELOAD_LO: prdata_next = {24'h0, reload_low_reg};
                `EBT_OFS_RELOAD_HI: prdata_next = {24'h0, reload_high_reg};
                `EBT_OFS_COUNT: prdata_next =
                    {24'h0, short_down_counter_reg};
                `EBT_OFS_IRQ_STAT: prdata_next = {30'h0, irq_stat_reg};
                `EBT_OFS_IRQ_MASK: prdata_next = {30'h0, irq_mask_reg};
                default: prdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= '0;
            sh_reg <= '0;
            state_reg <= EBT_IDLE;
            reload_low_reg <= `EBT_RELOAD_RST;
            reload_high_reg <= `EBT_RELOAD_RST;
            short_down_counter_reg <= `EBT_COUNT_RST;
            short_counter_output_level_reg <= 1'b0;
            stop_pend_reg <= 1'b0;
            clr_pend_reg <= 1'b0;
            div_reg <= '0;
            edge_prev_reg <= 1'b0;
            irq_stat_reg <= 2'h0;
            irq_mask_reg <= 2'h0;
            prdata_reg <= 32'h0;
            cap_rd_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            sh_reg <= sh_next;
            state_reg <= state_next;
            reload_low_reg <= reload_low_next;
            reload_high_reg <= reload_high_next;
            short_down_counter_reg <= short_down_counter_next;
            short_counter_output_level_reg <=
                short_counter_output_level_next;
            stop_pend_reg <= stop_pend_next;
            clr_pend_reg <= clr_pend_next;
            div_reg <= div_next;
            edge_prev_reg <= edge_prev_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            prdata_reg <= prdata_next;
            cap_rd_reg <= cap_rd_next;
        end
    end

    assign timer_output_pin = ctrl_reg.route
        ? short_counter_output_level_reg : port_out_value; // RL11
    assign irq = |(irq_stat_reg & irq_mask_reg); // RL18

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        tick && state_reg == EBT_COUNT && sh_reg.demod && ctrl_reg.en
        && short_down_counter_reg == 8'h00
        |=> short_down_counter_reg == 8'hff && !$rose(ctrl_reg.ts);
    endproperty
    a_wrap: assert property (p_wrap) // RL7
        else $error("wrap to FFh misbehaved");

    property p_ts_set;
        @(posedge pclk) disable iff (!presetn)
        terminal |=> ctrl_reg.ts;
    endproperty
    a_ts_set: assert property (p_ts_set) // RL3
        else $error("timeout not set at terminal count");

    property p_ts_hold;
        @(posedge pclk) disable iff (!presetn)
        ctrl_reg.ts && !(tick && clr_pend_reg) |=> ctrl_reg.ts;
    endproperty
    a_ts_hold: assert property (p_ts_hold) // RL3
        else $error("timeout cleared without deferred write");

    property p_stop_wait;
        @(posedge pclk) disable iff (!presetn)
        stop_pend_reg && !tick && !stop_wake_recovery && !terminal
        |=> ctrl_reg.en;
    endproperty
    a_stop_wait: assert property (p_stop_wait) // RL8
        else $error("stop acted before the timer clock");

    property p_single;
        @(posedge pclk) disable iff (!presetn)
        terminal && ctrl_reg.sp |=> state_reg == EBT_IDLE && !ctrl_reg.en;
    endproperty
    a_single: assert property (p_single) // RL2
        else $error("single-pass did not stop");

    property p_modn;
        @(posedge pclk) disable iff (!presetn)
        terminal && !ctrl_reg.sp && !stop_wake_recovery && !stop_pend_reg
        |=> state_reg == EBT_COUNT && short_down_counter_reg ==
        ($past(short_counter_output_level_reg)
        ? $past(reload_low_reg) : $past(reload_high_reg));
    endproperty
    a_modn: assert property (p_modn) // RL2
        else $error("modulo-N reload wrong");

    property p_wait;
        @(posedge pclk) disable iff (!presetn)
        state_reg == EBT_WAIT_EDGE && !edge_q && ctrl_reg.en
        && !stop_wake_recovery && !(tick && stop_pend_reg)
        |=> state_reg == EBT_WAIT_EDGE;
    endproperty
    a_wait: assert property (p_wait) // RL13
        else $error("count started without an edge");

    property p_cap;
        @(posedge pclk) disable iff (!presetn)
        cap_wr.we |=> u_cap.mem_reg[$past(cap_wr.sel)]
        == ~$past(short_down_counter_reg);
    endproperty
    a_cap: assert property (p_cap) // RL14
        else $error("capture value is not the complement");

    property p_route;
        @(posedge pclk) disable iff (!presetn)
        ctrl_reg.route |-> timer_output_pin
        == short_counter_output_level_reg;
    endproperty
    a_route: assert property (p_route) // RL11
        else $error("timer output not on pin");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        to_evt && ctrl_reg.ie && irq_mask_reg[0]
        && !(wr_acc && hit(`EBT_OFS_IRQ_MASK)) |=> irq;
    endproperty
    a_irq: assert property (p_irq) // RL10
        else $error("enabled timeout raised no interrupt");
endmodule

// ### hw/ebt_params.svh
// Constants of the eight-bit timer: offsets, fields, resets, timing
// Behaviour
// [RL1] Writing enable 1 starts the timer
// [RL2] Modulo-N reloads at terminal count; single-pass stops
// [RL3] Terminal count sets timeout; write 1 clears
// [RL4] Software clears timeout before enabling timer
// [RL5] First timer clock after enable may be short
// [RL6] Software avoids read-modify-write on timeout bit
// [RL7] Wrap from zero to FFh is no timeout
// [RL8] Stop and status clear act after one tick
// [RL9] Software stops and clears in separate writes
// [RL10] Interrupt enable gates timeout; wake keeps it
// [RL11] Bit 0 routes timer output to pin
// [RL12] Software loads both reloads with FFh first
// [RL13] Demodulation waits for first edge, then counts
// [RL14] Later edges capture complemented count
// [RL15] Edge input pin is selectable for demodulation
// [RL16] Reload chosen by current output level
// [RL17] Rising and falling captures use separate registers
// [RL18] Enabled timeout raises timer interrupt request
`ifndef EBT_PARAMS_SVH
`define EBT_PARAMS_SVH

`define EBT_OFS_CTRL 8'h00
`define EBT_OFS_SHARED 8'h04
`define EBT_OFS_RELOAD_LO 8'h08
`define EBT_OFS_RELOAD_HI 8'h0c
`define EBT_OFS_CAP_RISE 8'h10
`define EBT_OFS_CAP_FALL 8'h14
`define EBT_OFS_COUNT 8'h18
`define EBT_OFS_IRQ_STAT 8'h1c
`define EBT_OFS_IRQ_MASK 8'h20

`define EBT_CTRL_EN 7
`define EBT_CTRL_SP 6
`define EBT_CTRL_TS 5
`define EBT_CTRL_CLK_HI 4
`define EBT_CTRL_CLK_LO 3
`define EBT_CTRL_IE 1
`define EBT_CTRL_ROUTE 0

`define EBT_SH_DEMOD 7
`define EBT_SH_PINSEL 6
`define EBT_SH_EDGE_HI 5
`define EBT_SH_EDGE_LO 4
`define EBT_SH_INIT 1

`define EBT_IRQ_TIMEOUT 0
`define EBT_IRQ_CAPTURE 1

`define EBT_RELOAD_RST 8'hff
`define EBT_COUNT_RST 8'h00
`define EBT_TERMINAL 8'h00
`define EBT_DIV_W 4

`endif

// ### hw/ebt_pkg.sv
// Types shared by the eight-bit timer files
package ebt_pkg;

    typedef enum logic [1:0] {
        EBT_IDLE = 2'b00,
        EBT_WAIT_EDGE = 2'b01,
        EBT_COUNT = 2'b10
    } ebt_state_e;

    typedef struct packed {
        logic en;
        logic sp;
        logic ts;
        logic [1:0] clksel;
        logic ie;
        logic route;
    } ebt_ctrl_s;

    typedef struct packed {
        logic demod;
        logic pinsel;
        logic [1:0] edgesel;
        logic init_lvl;
    } ebt_shared_s;

    typedef struct packed {
        logic we;
        logic sel;
        logic [7:0] data;
    } ebt_cap_wr_s;

endpackage

// ### hw/ebt_capture_mem.sv
// Two-word capture store with registered read data
`timescale 1ns/1ps
`include "ebt_params.svh"
module ebt_capture_mem
    import ebt_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire ebt_cap_wr_s wr, // Write request
    input wire logic rd_sel, // Read word: 0 rising, 1 falling
    output logic [7:0] rd_data // Registered read data
);
    logic [7:0] mem_reg [2];
    logic [7:0] mem_next [2];
    logic [7:0] rd_next;

    always_comb begin
        mem_next[0] = mem_reg[0];
        mem_next[1] = mem_reg[1];
        if (wr.we) begin
            mem_next[wr.sel] = wr.data; // RL17
        end
        rd_next = mem_reg[rd_sel];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_reg[0] <= `EBT_COUNT_RST;
            mem_reg[1] <= `EBT_COUNT_RST;
            rd_data <= `EBT_COUNT_RST;
        end else begin
            mem_reg[0] <= mem_next[0];
            mem_reg[1] <= mem_next[1];
            rd_data <= rd_next;
        end
    end

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        !wr.we |=> mem_reg[0] == $past(mem_reg[0]);
    endproperty
    a_hold: assert property (p_hold) // RL17
        else $error("capture word changed without a write");
endmodule

// ### verification/tb.sv
// Self-checking bench for the eight-bit timer over APB
`timescale 1ns/1ps
`include "ebt_params.svh"
module tb;
    import ebt_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, last_err, timer_output_pin, irq;
    logic stop_wake_recovery = 0, edge_input_pin = 0, alt_edge_pin = 0;
    logic port_out_value = 0;
    int err_count = 0, cmp_count = 0, cyc = 0;
    localparam logic [31:0] EN = 32'h80, SP = 32'h40, TS = 32'h20;
    localparam logic [31:0] IE = 32'h02, RT = 32'h01;

    ebt_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stop_wake_recovery(stop_wake_recovery),
        .edge_input_pin(edge_input_pin), .alt_edge_pin(alt_edge_pin),
        .port_out_value(port_out_value),
        .timer_output_pin(timer_output_pin), .irq(irq));

    always #10 pclk = ~pclk;

    // Hang guard: whole run needs well under this many cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Request held until pready is sampled high; data taken at that edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        last_err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask

    task automatic rdc(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
        apb(0, a, '0);
        chk(what, exp, rd);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic wait_timeout();
        int i;
        for (i = 0; i < 60; i++) begin
            apb(0, `EBT_OFS_CTRL, '0);
            if (rd[`EBT_CTRL_TS] === 1'b1) break;
        end
    endtask

    task automatic test_reset_map();
        rdc("ctrl", `EBT_OFS_CTRL, 32'h0);
        rdc("reload low", `EBT_OFS_RELOAD_LO, 32'hff);
        rdc("reload high", `EBT_OFS_RELOAD_HI, 32'hff);
        rdc("count", `EBT_OFS_COUNT, 32'h0);
        rdc("capture rise", `EBT_OFS_CAP_RISE, 32'h0);
        rdc("irq mask", `EBT_OFS_IRQ_MASK, 32'h0);
        rdc("unmapped read", 8'h40, 32'h0);
        chk("pslverr", 32'h1, {31'h0, last_err});
        wr(8'h40, 32'h5a);
        chk("pslverr", 32'h1, {31'h0, last_err});
    endtask

    task automatic test_single_pass();
        wr(`EBT_OFS_CTRL, TS);
        wr(`EBT_OFS_IRQ_MASK, 32'h1);
        wr(`EBT_OFS_RELOAD_LO, 32'h3);
        wr(`EBT_OFS_RELOAD_HI, 32'h7);
        wr(`EBT_OFS_CTRL, EN | SP | IE | RT);
        wait_cyc(2);
        chk("pin level", 32'h0, {31'h0, timer_output_pin});
        wait_timeout();
        chk("timeout bit", 32'h1, {31'h0, rd[`EBT_CTRL_TS]});
        chk("pin toggled", 32'h1, {31'h0, timer_output_pin});
        wait_cyc(20);
        rdc("stopped count", `EBT_OFS_COUNT, 32'h0);
        chk("irq", 32'h1, {31'h0, irq});
        rdc("irq status", `EBT_OFS_IRQ_STAT, 32'h1);
        wait_cyc(2);
        chk("irq after clear", 32'h0, {31'h0, irq});
        wait_cyc(20);
        rdc("timeout sticky", `EBT_OFS_CTRL, SP | TS | IE | RT);
        wr(`EBT_OFS_CTRL, TS);
        wait_cyc(1);
        chk("pin as port", 32'h0, {31'h0, timer_output_pin});
        wait_cyc(10);
        rdc("timeout cleared", `EBT_OFS_CTRL, 32'h0);
    endtask

    task automatic test_modulo();
        logic [31:0] mx, c0;
        int i;
        mx = 0;
        wr(`EBT_OFS_RELOAD_LO, 32'h2);
        wr(`EBT_OFS_RELOAD_HI, 32'h5);
        // Tick every 4 cycles so 3-cycle polling cannot skip a value
        wr(`EBT_OFS_CTRL, EN | 32'h08);
        for (i = 0; i < 30; i++) begin
            apb(0, `EBT_OFS_COUNT, '0);
            if (rd > mx) mx = rd;
        end
        chk("max reload", 32'h5, mx);
        rdc("running", `EBT_OFS_CTRL, EN | TS | 32'h08);
        rdc("masked timeout", `EBT_OFS_IRQ_STAT, 32'h0);
        chk("irq off", 32'h0, {31'h0, irq});
        wr(`EBT_OFS_CTRL, 32'h0);
        wait_cyc(10);
        apb(0, `EBT_OFS_COUNT, '0);
        c0 = rd;
        wait_cyc(20);
        rdc("halted count", `EBT_OFS_COUNT, c0);
        rdc("status kept", `EBT_OFS_CTRL, TS);
        wr(`EBT_OFS_CTRL, TS);
        wait_cyc(10);
        rdc("cleared", `EBT_OFS_CTRL, 32'h0);
        wr(`EBT_OFS_CTRL, IE | SP | RT);
        @(posedge pclk) stop_wake_recovery <= 1;
        @(posedge pclk) stop_wake_recovery <= 0;
        wait_cyc(2);
        rdc("after wake", `EBT_OFS_CTRL, IE);
        wr(`EBT_OFS_CTRL, 32'h0);
    endtask

    task automatic test_demod();
        logic [31:0] cf;
        wr(`EBT_OFS_RELOAD_LO, 32'hff);
        wr(`EBT_OFS_RELOAD_HI, 32'hff);
        wr(`EBT_OFS_SHARED, 32'hb0);
        wr(`EBT_OFS_IRQ_MASK, 32'h3);
        apb(0, `EBT_OFS_COUNT, '0);
        cf = rd;
        wr(`EBT_OFS_CTRL, EN);
        wait_cyc(20);
        rdc("waiting count", `EBT_OFS_COUNT, cf);
        @(posedge pclk) edge_input_pin <= 1;
        wait_cyc(30);
        @(posedge pclk) edge_input_pin <= 0;
        wait_cyc(4);
        apb(0, `EBT_OFS_CAP_FALL, '0);
        cf = rd;
        chk("fall capture span", 32'h1, {31'h0, cf > 8 && cf < 30});
        rdc("capture event", `EBT_OFS_IRQ_STAT, 32'h2);
        wait_cyc(30);
        @(posedge pclk) edge_input_pin <= 1;
        wait_cyc(4);
        apb(0, `EBT_OFS_CAP_RISE, '0);
        chk("rise later", 32'h1, {31'h0, rd > cf && rd < 60});
        rdc("fall kept", `EBT_OFS_CAP_FALL, cf);
        wait_cyc(600);
        rdc("no wrap timeout", `EBT_OFS_CTRL, EN);
        // Only the capture bit of the rising edge is pending here
        rdc("no wrap irq", `EBT_OFS_IRQ_STAT, 32'h2);
        // Both pins high, so switching the source makes no edge
        @(posedge pclk) alt_edge_pin <= 1;
        wr(`EBT_OFS_SHARED, 32'hf0);
        @(posedge pclk) edge_input_pin <= 0;
        wait_cyc(6);
        rdc("main pin ignored", `EBT_OFS_IRQ_STAT, 32'h0);
        @(posedge pclk) alt_edge_pin <= 0;
        wait_cyc(6);
        chk("capture irq up", 32'h1, {31'h0, irq});
        rdc("alt pin edge", `EBT_OFS_IRQ_STAT, 32'h2);
        wait_cyc(1);
        chk("capture irq", 32'h0, {31'h0, irq});
        wr(`EBT_OFS_CTRL, 32'h0);
    endtask

    initial begin
        wait_cyc(20);
        @(posedge pclk) presetn <= 1;
        test_reset_map();
        test_single_pass();
        test_modulo();
        test_demod();
        tally_and_finish();
    end
endmodule
